// ---- pcdm_meter.v ----
// measurement core: scan schedule, integration, demand, serial output
// assumes an external ten-bit converter behind a three-way multiplexer
// Behaviour
// - four complete scans run every second, each sampling then computing.
// - each scan is an eleven line cycle sampling window then four line cycles of computation.
// - each phase result integrates 240 equally spaced samples over the sampling window.
// - present phase readings refresh once per scan.
// - peak demand readings refresh every fourth scan.
// - each demand is held in a 16-bit lagged register and a 16-bit peak register.
// - the lagged register follows current through a first-order lag set by the time constant.
// - the peak register keeps the largest lagged value since the last clear.
// - a peak reset clears both lagged and peak registers.
// - power-up zeroes the lagged register but leaves the peak register alone.
// - one ten-bit converter is shared by the phases through a multiplexer.
// - output values go out serially on two isolated channels.
// - channel one carries amplitude, channel two the address code.
// - amplitude spans zero to full scale and may reach 125 percent for overrange.
// - the firmware revision setting presents the revision level.
`include "pcdm_map.vh"
`timescale 1ns/1ps
module pcdm_meter
#(
  parameter SCAN_CLKS = `PCDM_SCAN_CLKS,
  parameter SAMPLE_CLKS = `PCDM_SAMPLE_CLKS,
  parameter SLOT_CLKS = `PCDM_SLOT_CLKS,
  parameter [7:0] FW_REV = 8'h01
)
(
  input wire sys_clk,
  input wire rst_b,
  input wire powerOn,
  input wire peakReset,
  input wire [3:0] timeConst,
  input wire [3:0] displaySel,
  input wire [9:0] adcData,
  input wire adcValid,
  output reg adcStart,
  output reg [1:0] muxSel,
  output reg serClk,
  output reg serAmp,
  output reg serAddr,
  output reg serLatch,
  output reg scanActive,
  output reg [1:0] presentSlot
);
  // peak values survive power cycles; a separate power-on marker
  // clears only the lagged registers

  // ----------------------------------------
  // scan schedule
  // ----------------------------------------
  localparam ST_SAMPLE = 2'h0;
  localparam ST_CALC = 2'h1;
  localparam ST_EMIT = 2'h2;
  localparam ST_IDLE = 2'h3;

  reg [1:0] state_reg;
  reg [24:0] scanCnt_reg;
  reg [19:0] slotCnt_reg;
  reg [1:0] phase_reg;
  reg [7:0] sampleCnt_reg;
  reg [1:0] scanNum_reg;
  reg pend_reg;
  reg [1:0] emitIdx_reg;
  reg emitPeak_reg;
  wire fifoInReady;

  wire scanEnd = (scanCnt_reg == SCAN_CLKS - 1);
  wire slotTick = (slotCnt_reg == SLOT_CLKS - 1);
  wire sampling = (state_reg == ST_SAMPLE);

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      scanCnt_reg <= 25'h0;
    else if (scanEnd)
      scanCnt_reg <= 25'h0;
    else
      scanCnt_reg <= scanCnt_reg + 25'h1;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slotCnt_reg <= 20'h0;
      phase_reg <= 2'h0;
      sampleCnt_reg <= 8'h0;
      adcStart <= 1'b0;
      muxSel <= 2'h0;
    end
    else
    begin
      adcStart <= 1'b0;
      if (scanEnd)
      begin
        slotCnt_reg <= 20'h0;
        phase_reg <= 2'h0;
        sampleCnt_reg <= 8'h0;
      end
      else if (sampling && sampleCnt_reg != `PCDM_SAMPLES_PER_PHASE)
      begin
        if (slotTick)
        begin
          slotCnt_reg <= 20'h0;
          muxSel <= phase_reg;
          adcStart <= 1'b1;
          if (phase_reg == 2'h2)
          begin
            phase_reg <= 2'h0;
            sampleCnt_reg <= sampleCnt_reg + 8'h1;
          end
          else
            phase_reg <= phase_reg + 2'h1;
        end
        else
          slotCnt_reg <= slotCnt_reg + 20'h1;
      end
    end
  end

  // ----------------------------------------
  // per-phase integration and demand
  // ----------------------------------------
  reg [1:0] capPhase_reg;
  reg calcPulse_reg;
  reg peakPulse_reg;
  reg [15:0] presVal [0:2];
  reg [15:0] lagVal [0:2];
  reg [15:0] peakVal [0:2];
  reg [15:0] peakOut [0:2];

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      capPhase_reg <= 2'h0;
    else if (adcStart)
      capPhase_reg <= muxSel;
  end

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : phase
      reg [17:0] acc_reg;
      wire [17:0] scaled = acc_reg; // sum of 240 ten-bit codes fits 18 bits
      wire [15:0] present = (scaled[17:2] > `PCDM_OVER_SCALE) ? `PCDM_OVER_SCALE
                            : scaled[17:2];
      wire signed [17:0] diff = $signed({2'b00, presVal[g]}) - $signed({2'b00, lagVal[g]});
      wire signed [17:0] step = diff >>> timeConst;
      wire [15:0] lagNext = lagVal[g] + step[15:0];

      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          acc_reg <= 18'h0;
        else if (scanEnd)
          acc_reg <= 18'h0;
        else if (adcValid && capPhase_reg == g)
          acc_reg <= acc_reg + {8'h0, adcData};
      end

      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          presVal[g] <= 16'h0;
          lagVal[g] <= 16'h0;
          peakOut[g] <= 16'h0;
        end
        else
        begin
          if (calcPulse_reg)
            presVal[g] <= present;
          if (peakReset || powerOn)
            lagVal[g] <= 16'h0;
          else if (peakPulse_reg)
            lagVal[g] <= lagNext;
          if (peakPulse_reg)
            peakOut[g] <= peakVal[g];
        end
      end

      // peak storage has no async clear: it stands for the retained memory
      always @(posedge sys_clk)
      begin
        if (peakReset)
          peakVal[g] <= 16'h0;
        else if (lagVal[g] > peakVal[g])
          peakVal[g] <= lagVal[g];
      end
    end
  endgenerate

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_SAMPLE;
      calcPulse_reg <= 1'b0;
      peakPulse_reg <= 1'b0;
      scanNum_reg <= 2'h0;
      pend_reg <= 1'b0;
      emitIdx_reg <= 2'h0;
      emitPeak_reg <= 1'b0;
      scanActive <= 1'b0;
    end
    else
    begin
      calcPulse_reg <= 1'b0;
      peakPulse_reg <= 1'b0;
      scanActive <= sampling;
      case (state_reg)
        ST_SAMPLE:
        begin
          if (scanCnt_reg == SAMPLE_CLKS - 1)
            state_reg <= ST_CALC;
        end
        ST_CALC:
        begin
          // the last start of the window is still converting here
          if (scanCnt_reg == SAMPLE_CLKS + `PCDM_SETTLE_CLKS - 1)
            calcPulse_reg <= 1'b1;
          if (scanCnt_reg == SAMPLE_CLKS + `PCDM_SETTLE_CLKS)
          begin
            if (scanNum_reg == `PCDM_SCANS_PER_PEAK - 1)
              peakPulse_reg <= 1'b1;
            scanNum_reg <= scanNum_reg + 2'h1;
            emitIdx_reg <= 2'h0;
            emitPeak_reg <= 1'b0;
            state_reg <= ST_EMIT;
          end
        end
        ST_EMIT:
        begin
          if (pend_reg)
            pend_reg <= 1'b0;
          else if (fifoInReady)
          begin
            pend_reg <= 1'b1;
            if (emitIdx_reg == 2'h2)
            begin
              emitIdx_reg <= 2'h0;
              if (emitPeak_reg)
                state_reg <= ST_IDLE;
              else
                emitPeak_reg <= 1'b1;
            end
            else
              emitIdx_reg <= emitIdx_reg + 2'h1;
          end
        end
        ST_IDLE:
        begin
          if (scanEnd)
            state_reg <= ST_SAMPLE;
        end
        default:
          state_reg <= ST_SAMPLE;
      endcase
      if (scanEnd)
        state_reg <= ST_SAMPLE;
    end
  end

  // ----------------------------------------
  // output words: amplitude plus address
  // ----------------------------------------
  reg [19:0] word;
  wire [19:0] fifoOut;
  wire fifoOutValid;
  reg fifoOutReady;
  wire emitValid = (state_reg == ST_EMIT) && !pend_reg;

  always @*
  begin
    word = 20'h0;
    if (displaySel == `PCDM_SEL_FWREV)
      word = {`PCDM_SEL_FWREV, 8'h00, FW_REV};
    else if (emitPeak_reg)
      word = {`PCDM_SEL_PEAK + {2'b00, emitIdx_reg}, peakOut[emitIdx_reg]};
    else
      word = {`PCDM_SEL_PRESENT + {2'b00, emitIdx_reg}, presVal[emitIdx_reg]};
  end

  pcdm_skid u_skid
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .inData(word),
    .inValid(emitValid),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // ----------------------------------------
  // serialiser for the two isolated channels
  // ----------------------------------------
  reg [15:0] ampSh_reg;
  reg [15:0] addrSh_reg;
  reg [4:0] bitCnt_reg;
  reg busy_reg;

  always @*
  begin
    fifoOutReady = !busy_reg;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ampSh_reg <= 16'h0;
      addrSh_reg <= 16'h0;
      bitCnt_reg <= 5'h0;
      busy_reg <= 1'b0;
      serClk <= 1'b0;
      serAmp <= 1'b0;
      serAddr <= 1'b0;
      serLatch <= 1'b0;
      presentSlot <= 2'h0;
    end
    else
    begin
      serLatch <= 1'b0;
      if (!busy_reg)
      begin
        serClk <= 1'b0;
        if (fifoOutValid)
        begin
          ampSh_reg <= fifoOut[15:0];
          addrSh_reg <= {12'h000, fifoOut[19:16]};
          presentSlot <= fifoOut[17:16];
          bitCnt_reg <= 5'h0;
          busy_reg <= 1'b1;
        end
      end
      else if (!serClk)
      begin
        serAmp <= ampSh_reg[15];
        serAddr <= addrSh_reg[15];
        serClk <= 1'b1;
      end
      else
      begin
        serClk <= 1'b0;
        ampSh_reg <= {ampSh_reg[14:0], 1'b0};
        addrSh_reg <= {addrSh_reg[14:0], 1'b0};
        if (bitCnt_reg == `PCDM_SER_BITS - 1)
        begin
          busy_reg <= 1'b0;
          serLatch <= 1'b1;
        end
        bitCnt_reg <= bitCnt_reg + 5'h1;
      end
    end
  end
endmodule // pcdm_meter

// ---- pcdm_map.vh ----
// constants for the phase current demand meter core
// assumes a 50 MHz system clock and a 60 Hz fixed line frequency
`ifndef PCDM_MAP_VH
`define PCDM_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define PCDM_CLK_HZ 50000000
`define PCDM_LINE_HZ 60
`define PCDM_SCANS_PER_SEC 4
`define PCDM_SAMPLE_LINE_CYCLES 11
`define PCDM_CALC_LINE_CYCLES 4
`define PCDM_SAMPLES_PER_PHASE 240
`define PCDM_PHASES 3
// clocks per scan: one quarter second
`define PCDM_SCAN_CLKS (`PCDM_CLK_HZ / `PCDM_SCANS_PER_SEC)
// clocks per line cycle, rounded down
`define PCDM_LINE_CLKS (`PCDM_CLK_HZ / `PCDM_LINE_HZ)
// sampling window length in clocks
`define PCDM_SAMPLE_CLKS (`PCDM_LINE_CLKS * `PCDM_SAMPLE_LINE_CYCLES)
// spacing between samples of one phase
`define PCDM_SAMPLE_SPACING (`PCDM_SAMPLE_CLKS / `PCDM_SAMPLES_PER_PHASE)
// spacing between successive multiplexer slots
`define PCDM_SLOT_CLKS (`PCDM_SAMPLE_SPACING / `PCDM_PHASES)
`define PCDM_SCANS_PER_PEAK 4
// margin after the window so the last conversion lands before results latch
`define PCDM_SETTLE_CLKS 16

// ----------------------------------------
// widths and codes
// ----------------------------------------
`define PCDM_ADC_W 10
`define PCDM_ACC_W 18
`define PCDM_VAL_W 16
`define PCDM_TC_W 4
`define PCDM_ADDR_W 4
// full scale for the amplitude channel; 125 percent overrange clamp
`define PCDM_FULL_SCALE 16'h3000
`define PCDM_OVER_SCALE 16'h3C00
// address codes on the second output channel
`define PCDM_SEL_PRESENT 4'hA
`define PCDM_SEL_PEAK 4'hD
`define PCDM_SEL_FWREV 4'h8
// serial word length per output channel
`define PCDM_SER_BITS 16

`endif

// ---- pcdm_skid.v ----
// two-entry buffer between the scan logic and the serial output stage
// assumes producer and consumer on the same clock
`timescale 1ns/1ps
module pcdm_skid
(
  input wire sys_clk,
  input wire rst_b,
  input wire [19:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [19:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [19:0] mem [0:1];
  reg wrPtr_reg;
  reg rdPtr_reg;
  reg [1:0] count_reg;
  wire doWrite;
  wire doRead;

  assign inReady = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData = mem[rdPtr_reg];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always @(posedge sys_clk)
  begin
    if (doWrite)
      mem[wrPtr_reg] <= inData;
  end

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrPtr_reg <= 1'b0;
      rdPtr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (doWrite)
        wrPtr_reg <= ~wrPtr_reg;
      if (doRead)
        rdPtr_reg <= ~rdPtr_reg;
      if (doWrite && !doRead)
        count_reg <= count_reg + 2'h1;
      else if (doRead && !doWrite)
        count_reg <= count_reg - 2'h1;
    end
  end
endmodule // pcdm_skid

// ---- pcdm_meter_sva.sv ----
// port checker for the demand meter core
// assumes one clock domain; bound to every pcdm_meter instance
`timescale 1ns/1ps
module pcdm_meter_sva
#(
  parameter SCAN_CLKS = 30000,
  parameter SAMPLE_CLKS = 21600
)
(
  input wire sys_clk,
  input wire rst_b,
  input wire adcStart,
  input wire [1:0] muxSel,
  input wire serClk,
  input wire serAmp,
  input wire serAddr,
  input wire serLatch,
  input wire scanActive
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  reg prev_reg;
  reg seen_reg;
  reg [31:0] hiCnt_reg;
  reg [31:0] perCnt_reg;
  // ----------------------------------------
  // window and period counters
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_reg <= 1'b0;
      seen_reg <= 1'b0;
      hiCnt_reg <= 0;
      perCnt_reg <= 0;
    end
    else
    begin
      prev_reg <= scanActive;
      hiCnt_reg <= scanActive ? hiCnt_reg + 1 : 0;
      perCnt_reg <= (scanActive && !prev_reg) ? 1 : perCnt_reg + 1;
      if (scanActive && !prev_reg)
        seen_reg <= 1'b1;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_start_one_cycle: assert property (adcStart |=> !adcStart)
    else $error("converter start longer than one cycle");
  a_mux_in_range: assert property (muxSel != 2'h3)
    else $error("multiplexer select out of range");
  a_start_in_window: assert property (adcStart |-> scanActive)
    else $error("converter start outside sampling window");
  a_window_length: assert property ($fell(scanActive) |-> hiCnt_reg == SAMPLE_CLKS)
    else $error("sampling window length wrong");
  a_scan_period: assert property ((scanActive && !prev_reg && seen_reg) |-> perCnt_reg == SCAN_CLKS)
    else $error("scan period wrong");
  a_latch_one_cycle: assert property (serLatch |=> !serLatch)
    else $error("latch pulse longer than one cycle");
  a_latch_in_calc: assert property (serLatch |-> !scanActive && !serClk)
    else $error("word latched during sampling");
  a_serclk_half: assert property (serClk |=> !serClk)
    else $error("serial clock high too long");
  a_bits_stand: assert property ($fell(serClk) |-> $stable(serAmp) && $stable(serAddr))
    else $error("serial bit changed mid bit");
endmodule // pcdm_meter_sva

bind pcdm_meter pcdm_meter_sva #(.SCAN_CLKS(SCAN_CLKS), .SAMPLE_CLKS(SAMPLE_CLKS)) u_sva
(
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .adcStart(adcStart),
  .muxSel(muxSel),
  .serClk(serClk),
  .serAmp(serAmp),
  .serAddr(serAddr),
  .serLatch(serLatch),
  .scanActive(scanActive)
);

// ---- pcdm_adc_model.sv ----
// converter model behind the phase multiplexer
// assumes starts at least three cycles apart; latency alternates 1 and 2
`timescale 1ns/1ps
module pcdm_adc_model
(
  input wire sys_clk,
  input wire rst_b,
  input wire adcStart,
  input wire [1:0] muxSel,
  input wire [9:0] lvl0,
  input wire [9:0] lvl1,
  input wire [9:0] lvl2,
  output reg [9:0] adcData,
  output reg adcValid
);
  reg [1:0] wait_reg;
  reg slow_reg;
  reg [9:0] held_reg;
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_reg <= 2'h0;
      slow_reg <= 1'b0;
      held_reg <= 10'h000;
      adcValid <= 1'b0;
      adcData <= 10'h2AA;
    end
    else
    begin
      adcValid <= 1'b0;
      // idle bus shows the inverse so stale data never passes
      adcData <= ~held_reg;
      if (adcStart)
      begin
        // one ten-bit converter, channel picked by the select
        held_reg <= (muxSel == 2'h0) ? lvl0 : (muxSel == 2'h1) ? lvl1 : lvl2;
        wait_reg <= slow_reg ? 2'h2 : 2'h1;
        slow_reg <= ~slow_reg;
      end
      else if (wait_reg != 2'h0)
      begin
        wait_reg <= wait_reg - 2'h1;
        if (wait_reg == 2'h1)
        begin
          adcValid <= 1'b1;
          adcData <= held_reg;
        end
      end
    end
  end
endmodule // pcdm_adc_model

// ---- testbench.sv ----
// self-checking bench for pcdm_meter with shortened scan counts
// assumes the converter model answers every start
`timescale 1ns/1ps
module testbench;
  localparam [15:0] SCAN = 16'h0B9A;
  localparam [15:0] SAMP = 16'h0870;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg powerOn = 1'b0;
  reg peakReset = 1'b0;
  reg [3:0] timeConst = 4'h0;
  reg [3:0] displaySel = 4'h0;
  reg [9:0] lvl0 = 10'h064;
  reg [9:0] lvl1 = 10'h0C8;
  reg [9:0] lvl2 = 10'h3FF;
  wire [9:0] adcData;
  wire adcValid, adcStart, serClk, serAmp, serAddr, serLatch, scanActive;
  wire [1:0] muxSel;
  wire [1:0] presentSlot;
  integer bad_count = 0;
  integer total_checks = 0;
  integer startCnt = 0;
  integer i, n, m, k;
  reg prevSer = 1'b0;
  reg [15:0] shAmp = 16'h0000;
  reg [15:0] shAddr = 16'h0000;
  reg [15:0] ampQ[$];
  reg [15:0] addrQ[$];
  reg [15:0] old0, old1, old2;
  initial forever #10 sys_clk = ~sys_clk;
  pcdm_meter #(.SCAN_CLKS(2970), .SAMPLE_CLKS(2160), .SLOT_CLKS(3), .FW_REV(8'h3C)) dut
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .powerOn(powerOn), .peakReset(peakReset),
    .timeConst(timeConst), .displaySel(displaySel), .adcData(adcData),
    .adcValid(adcValid), .adcStart(adcStart), .muxSel(muxSel), .serClk(serClk),
    .serAmp(serAmp), .serAddr(serAddr), .serLatch(serLatch),
    .scanActive(scanActive), .presentSlot(presentSlot)
  );
  pcdm_adc_model u_adc
  (
    .sys_clk(sys_clk), .rst_b(rst_b), .adcStart(adcStart), .muxSel(muxSel),
    .lvl0(lvl0), .lvl1(lvl1), .lvl2(lvl2), .adcData(adcData), .adcValid(adcValid)
  );
  // ----------------------------------------
  // serial word capture, bits taken on serial clock rise
  // ----------------------------------------
  always @(negedge sys_clk)
  begin
    prevSer <= serClk;
    if (serClk && !prevSer)
    begin
      shAmp <= {shAmp[14:0], serAmp};
      shAddr <= {shAddr[14:0], serAddr};
    end
    if (serLatch)
    begin
      check({14'h0000, presentSlot}, {14'h0000, shAddr[1:0]});
      ampQ.push_back(shAmp);
      addrQ.push_back(shAddr);
    end
    if (adcStart)
      startCnt <= startCnt + 1;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function [15:0] pres(input [9:0] v);
    reg [17:0] t;
  begin
    t = 18'h0003C * v;
    pres = (t > 18'h03C00) ? 16'h3C00 : t[15:0];
  end
  endfunction
  task print_verdict;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task tick;
  begin
    @(negedge sys_clk);
    #1;
  end
  endtask
  task check(input [15:0] seen, input [15:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wait_level(input v, output integer c);
  begin
    c = 0;
    while (scanActive !== v && c < SCAN)
    begin
      tick;
      c = c + 1;
    end
    if (c >= SCAN)
    begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  endtask
  task grab;
  begin
    wait_level(1'b0, n);
    wait_level(1'b1, n);
    ampQ.delete();
    addrQ.delete();
    k = 0;
    while (ampQ.size() < 6 && k < SCAN)
    begin
      tick;
      k = k + 1;
    end
    if (k >= SCAN)
    begin
      bad_count = bad_count + 1;
      print_verdict;
    end
  end
  endtask
  task pulse_power;
  begin
    powerOn = 1'b1;
    tick;
    powerOn = 1'b0;
  end
  endtask
  task pulse_clear;
  begin
    peakReset = 1'b1;
    tick;
    peakReset = 1'b0;
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task test_schedule;
  begin
    wait_level(1'b0, n);
    wait_level(1'b1, n);
    m = startCnt;
    wait_level(1'b0, n);
    check(n[15:0], SAMP);
    check(startCnt - m, 16'h02D0);
    wait_level(1'b1, m);
    check(n[15:0] + m[15:0], SCAN);
    $display("test schedule done");
  end
  endtask
  task test_present;
  begin
    grab;
    for (i = 0; i < 6; i = i + 1)
      check({12'h000, addrQ[i][3:0]}, 16'h000A + i);
    check(ampQ[0], pres(lvl0));
    check(ampQ[1], pres(lvl1));
    check(ampQ[2], 16'h3C00);
    $display("test present done");
  end
  endtask
  task test_peak;
  begin
    i = 0;
    grab;
    while (ampQ[3] !== pres(lvl0) && i < 8)
    begin
      grab;
      i = i + 1;
    end
    old0 = pres(lvl0);
    old1 = pres(lvl1);
    old2 = pres(lvl2);
    check(ampQ[3], old0);
    check(ampQ[4], old1);
    check(ampQ[5], old2);
    lvl0 = 10'h032;
    lvl1 = 10'h032;
    lvl2 = 10'h032;
    pulse_power;
    repeat (6) grab;
    check(ampQ[0], pres(10'h032));
    check(ampQ[3], old0);
    check(ampQ[4], old1);
    check(ampQ[5], old2);
    pulse_clear;
    i = 0;
    grab;
    while (ampQ[3] !== pres(10'h032) && i < 8)
    begin
      grab;
      i = i + 1;
    end
    check(ampQ[3], pres(10'h032));
    check(ampQ[5], pres(10'h032));
    $display("test peak done");
  end
  endtask
  task test_fwrev;
  begin
    displaySel = 4'h8;
    grab;
    grab;
    for (i = 0; i < 6; i = i + 1)
    begin
      check({12'h000, addrQ[i][3:0]}, 16'h0008);
      check(ampQ[i], 16'h003C);
    end
    displaySel = 4'h0;
    $display("test fwrev done");
  end
  endtask
  initial
  begin
    repeat (3) tick;
    rst_b = 1'b1;
    // peak registers have no reset, so clear them first
    pulse_clear;
    test_schedule;
    test_present;
    test_peak;
    test_fwrev;
    print_verdict;
  end
endmodule // testbench
